// File: verilog/reset_timeout_sequencer.sv
// reset timeout sequencer: reset sources, timers, cause flags, pc select, apb
`timescale 1ns/10ps
module reset_timeout_sequencer
  import rts_pkg::*;
#(
  parameter int unsigned PUP_CYCLES     = PUP_CYC,
  parameter int unsigned BORQ_CYCLES    = BORQ_CYC,
  parameter int unsigned STARTUP_CYCLES = STARTUP_COUNT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_ok,
  input  wire logic        brownout_low,
  input  wire logic        master_clear_n,
  input  wire logic        osc_in,
  input  wire logic        wdt_timeout,
  input  wire logic        wake_int,
  input  wire logic        sleep_enter,
  input  wire logic        global_int_enable,
  input  wire logic [12:0] pc_current,
  output logic             core_reset,
  output logic             pc_load,
  output logic      [12:0] pc_value,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] sup_m_q, low_m_q, clr_m_q, osc_m_q;
  logic       sup_s, low_s, clr_s, osc_s, clr_d1_q, osc_d1_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_m_q  <= 2'h0;
      low_m_q  <= 2'h0;
      clr_m_q  <= 2'h0;
      osc_m_q  <= 2'h0;
      clr_d1_q <= 1'b0;
      osc_d1_q <= 1'b0;
    end else begin
      sup_m_q  <= {sup_m_q[0], supply_ok};
      low_m_q  <= {low_m_q[0], brownout_low};
      clr_m_q  <= {clr_m_q[0], master_clear_n};
      osc_m_q  <= {osc_m_q[0], osc_in};
      clr_d1_q <= clr_m_q[1];
      osc_d1_q <= osc_m_q[1];
    end
  end

  assign sup_s = sup_m_q[1];
  assign low_s = low_m_q[1];
  assign clr_s = clr_m_q[1];
  assign osc_s = osc_m_q[1];

  ////////////////////////////////////////////////////////////////
  // configuration and events
  logic [3:0]  cfg_q;
  logic        pup_en_n, low_en, xtal, pup_on, osc_rise;
  osc_mode_t   osc_mode;
  seq_state_t  state_q, state_d;
  logic [31:0] tmr_q, bq_q;
  logic        por_evt, low_evt, wdt_rst, wdt_wake, int_wake, wake_evt;
  logic        clr_fall, sleep_evt, pup_done, startup_done, awake;

  assign pup_en_n     = cfg_q[CFG_PWRTEN_BIT];
  assign low_en       = cfg_q[CFG_BOREN_BIT];
  assign osc_mode     = osc_mode_t'(cfg_q[CFG_OSC_LSB +: 2]);
  assign xtal         = (osc_mode != OSC_RES_CAP);
  assign pup_on       = !pup_en_n || low_en;
  assign osc_rise     = osc_s && !osc_d1_q;
  assign awake        = (state_q == ST_RUN);

  assign por_evt      = (state_q == ST_OFF) && sup_s;
  assign low_evt      = low_en && low_s && (bq_q == BORQ_CYCLES - 1) &&
                        (state_q != ST_OFF) && (state_q != ST_LOW_HOLD);
  assign wdt_rst      = wdt_timeout && awake && !core_reset;
  assign wdt_wake     = wdt_timeout && (state_q == ST_SLEEP);
  assign int_wake     = wake_int && (state_q == ST_SLEEP);
  assign wake_evt     = wdt_wake || int_wake;
  assign clr_fall     = clr_d1_q && !clr_s;
  assign sleep_evt    = sleep_enter && awake && !core_reset;
  assign pup_done     = (tmr_q == PUP_CYCLES - 1);
  assign startup_done = osc_rise && (tmr_q == STARTUP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (sup_s) begin
          state_d = pup_on ? ST_PUP : (xtal ? ST_STARTUP : ST_RUN);
        end
      end
      ST_LOW_HOLD: begin
        if (!low_s) begin
          state_d = ST_PUP;
        end
      end
      ST_PUP: begin
        if (low_en && low_s) begin
          state_d = ST_LOW_HOLD;
        end else if (pup_done) begin
          state_d = xtal ? ST_STARTUP : ST_RUN;
        end
      end
      ST_STARTUP: begin
        if (startup_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_evt) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_evt) begin
          state_d = xtal ? ST_STARTUP : ST_RUN;
        end else if (clr_fall) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_OFF;
    endcase
    if (low_evt) begin
      state_d = ST_LOW_HOLD;
    end
    if (!sup_s) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // one counter serves both timers; cleared on every state change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= 32'h0;
    end else if (state_d != state_q) begin
      tmr_q <= 32'h0;
    end else if (state_q == ST_PUP || (state_q == ST_STARTUP && osc_rise)) begin
      tmr_q <= tmr_q + 32'h1;
    end
  end

  // short dips never reach the qualify count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bq_q <= 32'h0;
    end else if (!low_s || !low_en || low_evt) begin
      bq_q <= 32'h0;
    end else if (bq_q != BORQ_CYCLES - 1) begin
      bq_q <= bq_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // internal reset and pc select
  logic core_reset_d, wake_q;

  // wdt reset costs one cycle of hold; master_clear_n release is immediate
  assign core_reset_d = (!awake && state_q != ST_SLEEP) || !clr_s || wdt_rst;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= core_reset_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else if (wake_evt) begin
      wake_q <= 1'b1;
    end else if (awake || !sup_s || low_evt || !clr_s) begin
      wake_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load  <= 1'b0;
      pc_value <= PC_RESET;
    end else begin
      pc_load <= 1'b0;
      if (int_wake && global_int_enable) begin
        pc_load  <= 1'b1;
        pc_value <= PC_VECTOR;
      end else if (wake_evt) begin
        pc_load  <= 1'b1;
        pc_value <= pc_current + 13'h1;
      end else if (core_reset && !core_reset_d && !wake_q) begin
        pc_load  <= 1'b1;
        pc_value <= PC_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // cause flags: hardware events win over software writes
  logic expired_n_q, slept_n_q, por_n_q, borf_q;
  logic apb_wr, acc;

  assign acc    = psel && penable && pready;
  assign apb_wr = acc && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expired_n_q <= 1'b1;
      slept_n_q   <= 1'b1;
    end else if (por_evt || low_evt) begin
      expired_n_q <= 1'b1;
      slept_n_q   <= 1'b1;
    end else if (wdt_rst) begin
      expired_n_q <= 1'b0;
    end else if (wdt_wake) begin
      expired_n_q <= 1'b0;
      slept_n_q   <= 1'b0;
    end else if (int_wake || (state_q == ST_SLEEP && clr_fall)) begin
      expired_n_q <= 1'b1;
      slept_n_q   <= 1'b0;
    end else if (sleep_evt) begin
      expired_n_q <= 1'b1;
      slept_n_q   <= 1'b0;
    end
    // pin clear while running touches nothing here
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_n_q <= POWER_RESET_FLAGS_RESET[PORN_BIT];
      borf_q  <= POWER_RESET_FLAGS_RESET[BORF_BIT];
    end else begin
      if (por_evt) begin
        por_n_q <= 1'b0;
      end else if (apb_wr && paddr == OFS_PWR_FLAGS) begin
        por_n_q <= pwdata[PORN_BIT];
      end
      if (low_evt) begin
        borf_q <= 1'b0;
      end else if (apb_wr && paddr == OFS_PWR_FLAGS) begin
        borf_q <= pwdata[BORF_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // interrupts
  logic [EV_W-1:0] int_stat_q, int_en_q, ev_vec, int_clr;

  always_comb begin
    ev_vec          = '0;
    ev_vec[EV_POR]  = por_evt;
    ev_vec[EV_LOW]     = low_evt;
    ev_vec[EV_WDT]     = wdt_rst;
    ev_vec[EV_WAKE]    = wake_evt;
    ev_vec[EV_PIN_CLR] = clr_fall;
  end

  assign int_clr = (apb_wr && paddr == OFS_INT_CLR) ? pwdata[EV_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= '0;
      irq        <= 1'b0;
    end else begin
      int_stat_q <= (int_stat_q & ~int_clr) | ev_vec;
      irq        <= |(((int_stat_q & ~int_clr) | ev_vec) & int_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb slave: answers in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q    <= CFG_RESET;
      int_en_q <= '0;
    end else if (apb_wr && paddr == OFS_CONFIG) begin
      cfg_q <= pwdata[3:0];
    end else if (apb_wr && paddr == OFS_INT_EN) begin
      int_en_q <= pwdata[EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        if (paddr == OFS_CORE_STAT) begin
          prdata[EXPIRED_BIT] <= expired_n_q;
          prdata[SLEPT_BIT]   <= slept_n_q;
        end else if (paddr == OFS_PWR_FLAGS) begin
          prdata[PORN_BIT] <= por_n_q;
          prdata[BORF_BIT] <= borf_q;
        end else if (paddr == OFS_CONFIG) begin
          prdata[3:0] <= cfg_q;
        end else if (paddr == OFS_SEQ_STATE) begin
          prdata[3:0] <= {core_reset, state_q};
        end else if (paddr == OFS_INT_STAT) begin
          prdata[EV_W-1:0] <= int_stat_q;
        end else if (paddr == OFS_INT_EN) begin
          prdata[EV_W-1:0] <= int_en_q;
        end else if (paddr != OFS_INT_CLR) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_low_recover;
    state_q == ST_LOW_HOLD && !low_s ##1 state_q == ST_PUP;
  endsequence

  a_clr_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !clr_s |=> core_reset) else $error("core not reset under master clear");
  a_clr_release: assert property (@(posedge pclk) disable iff (!presetn)
    awake && clr_s && !wdt_rst |=> !core_reset) else $error("late release");
  a_pup_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_PUP |=> core_reset) else $error("released during power-up delay");
  a_low_forces_pup: assert property (@(posedge pclk) disable iff (!presetn)
    sup_s && !low_evt |-> s_low_recover or not (state_q == ST_LOW_HOLD && !low_s))
    else $error("no power-up delay after brown-out");
  a_low_restart: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_PUP && low_en && low_s && sup_s |=> state_q == ST_LOW_HOLD)
    else $error("brown-out not restarted");
  a_rescap_skip: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_PUP && pup_done && !xtal && !low_s && sup_s && !low_evt |=> state_q == ST_RUN)
    else $error("start-up count in rc mode");
  a_startup_length: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_STARTUP && sup_s && !low_evt && !startup_done |=> state_q == ST_STARTUP)
    else $error("start-up count ended early");
  a_por_flags: assert property (@(posedge pclk) disable iff (!presetn)
    por_evt |=> !por_n_q && expired_n_q && slept_n_q) else $error("power-on flags wrong");
  a_low_flag: assert property (@(posedge pclk) disable iff (!presetn)
    low_evt |=> !borf_q && state_q == ST_LOW_HOLD) else $error("brown-out flag not cleared");
  a_wdt_reset: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_rst |=> !expired_n_q && core_reset) else $error("watchdog reset wrong");
  a_int_vector: assert property (@(posedge pclk) disable iff (!presetn)
    int_wake && global_int_enable |=> pc_load && pc_value == PC_VECTOR) else $error("bad wake vector");
  a_clr_flags: assert property (@(posedge pclk) disable iff (!presetn)
    awake && clr_fall && !wdt_rst && !sleep_evt && !low_evt |=> $stable(expired_n_q) && $stable(slept_n_q))
    else $error("master clear changed flags");

endmodule

// File: inc/rts_pkg.sv
// constants, offsets and types for the reset timeout sequencer
package rts_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned PUP_TIME_US    = 72000;
  localparam int unsigned PUP_CYC        = PUP_TIME_US * CLK_MHZ;
  localparam int unsigned BORQ_TIME_US   = 100;
  localparam int unsigned BORQ_CYC       = BORQ_TIME_US * CLK_MHZ;
  localparam int unsigned STARTUP_COUNT  = 1024;
  localparam logic [11:0] OFS_CORE_STAT  = 12'h000;
  localparam logic [11:0] OFS_PWR_FLAGS  = 12'h004;
  localparam logic [11:0] OFS_CONFIG     = 12'h008;
  localparam logic [11:0] OFS_SEQ_STATE  = 12'h00c;
  localparam logic [11:0] OFS_INT_STAT   = 12'h010;
  localparam logic [11:0] OFS_INT_CLR    = 12'h014;
  localparam logic [11:0] OFS_INT_EN     = 12'h018;
  localparam int unsigned EXPIRED_BIT    = 4;
  localparam int unsigned SLEPT_BIT      = 3;
  localparam int unsigned PORN_BIT       = 1;
  localparam int unsigned BORF_BIT       = 0;
  localparam int unsigned CFG_PWRTEN_BIT = 0;
  localparam int unsigned CFG_BOREN_BIT  = 1;
  localparam int unsigned CFG_OSC_LSB    = 2;
  localparam logic [3:0]  CFG_RESET      = 4'h2;
  localparam logic [1:0]  POWER_RESET_FLAGS_RESET     = 2'h0;
  localparam logic [12:0] PC_RESET       = 13'h0000;
  localparam logic [12:0] PC_VECTOR      = 13'h0004;
  localparam int unsigned EV_POR         = 0;
  localparam int unsigned EV_LOW         = 1;
  localparam int unsigned EV_WDT         = 2;
  localparam int unsigned EV_WAKE        = 3;
  localparam int unsigned EV_PIN_CLR     = 4;
  localparam int unsigned EV_W           = 5;
  typedef enum logic [1:0] {OSC_LOW_XTAL, OSC_XTAL, OSC_FAST_XTAL, OSC_RES_CAP} osc_mode_t;
  typedef enum logic [2:0] {ST_OFF, ST_LOW_HOLD, ST_PUP, ST_STARTUP, ST_RUN, ST_SLEEP} seq_state_t;
endpackage

// File: verif/supply_partner.sv
// supply monitor comparators, master clear pin and crystal model
`timescale 1ns/10ps
module supply_partner (
  input  wire logic pclk,
  input  wire logic vdd_on,
  input  wire logic vdd_low,
  input  wire logic master_clear_n_hold,
  output logic      supply_ok,
  output logic      brownout_low,
  output logic      master_clear_n,
  output logic      osc_in
);
  logic [2:0] div_q;
  assign supply_ok      = vdd_on;
  assign brownout_low   = vdd_on & vdd_low;
  assign master_clear_n = ~master_clear_n_hold;
  ////////////////////////////////////////
  // crystal dead without supply; pclk/8 stays under the sync limit
  always_ff @(posedge pclk) begin
    div_q <= vdd_on ? div_q + 3'h1 : 3'h0;
  end
  assign osc_in = div_q[2];
endmodule

// File: verif/reset_timeout_sequencer_tb_top.sv
// self-checking bench for the reset timeout sequencer
`timescale 1ns/10ps
module reset_timeout_sequencer_tb_top;
  import rts_pkg::*;
  localparam int PW = 20;
  localparam int BQ = 5;
  localparam int OC = 8;
  logic        pclk, presetn, psel, penable, pwrite, global_int_enable;
  logic        vdd_on, vdd_low, master_clear_n_hold, pready, pslverr, core_reset, pc_load, irq;
  logic        supply_ok, brownout_low, master_clear_n, osc_in;
  logic [2:0]  ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] pc_current, pc_value, last_pc;
  int          bad_count, n_checks, loads, cyc;
  reset_timeout_sequencer #(.PUP_CYCLES(PW), .BORQ_CYCLES(BQ), .STARTUP_CYCLES(OC)) reset_timeout_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
    .brownout_low(brownout_low), .master_clear_n(master_clear_n), .osc_in(osc_in),
    .wdt_timeout(ev[0]), .wake_int(ev[1]), .sleep_enter(ev[2]), .global_int_enable(global_int_enable),
    .pc_current(pc_current), .core_reset(core_reset), .pc_load(pc_load), .pc_value(pc_value), .irq(irq));
  supply_partner supply_partner_inst (.pclk(pclk), .vdd_on(vdd_on), .vdd_low(vdd_low), .master_clear_n_hold(master_clear_n_hold),
    .supply_ok(supply_ok), .brownout_low(brownout_low), .master_clear_n(master_clear_n), .osc_in(osc_in));
  always #5 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic fail(input string m);
    bad_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x, input string m);
    n_checks++;
    if (g !== x) fail(m);
  endtask
  task automatic chk_bit(input logic g, input logic x, input string m);
    n_checks++;
    if (g !== x) fail(m);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk_word(r & m, x, "read data");
    chk_bit(e, xe, "slave error");
  endtask
  task automatic wait_run(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (core_reset !== 1'b0 && n < 2000);
    if (n >= 2000) fail("core never released");
  endtask
  // one-cycle core event, then settle time for sync and pc load
  task automatic fire(input logic [2:0] k);
    ev <= k;
    @(posedge pclk);
    ev <= 3'h0;
    repeat (12) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (pc_load === 1'b1) begin
      last_pc = pc_value;
      loads++;
    end
    if (cyc == 20000) begin
      fail("timeout");
      stop_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    int n;
    {pclk, presetn, psel, penable, pwrite, global_int_enable, vdd_on, vdd_low, master_clear_n_hold} = '0;
    {ev, paddr, pwdata, bad_count, n_checks, loads, cyc} = '0;
    pc_current = 13'h0123;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFS_CONFIG, 32'h2, 32'hf, 1'b0);
    rd_chk(12'h040, 32'h0, 32'hffffffff, 1'b1);
    wr(OFS_INT_EN, 32'h1f);
    vdd_on <= 1'b1;
    wait_run(n);
    chk_bit(n >= PW + (OC - 1) * 8, 1'b1, "power-up hold short");
    rd_chk(OFS_CORE_STAT, 32'h18, 32'h18, 1'b0);
    rd_chk(OFS_SEQ_STATE, 32'h4, 32'hf, 1'b0);
    chk_bit(loads == 1 && last_pc === 13'h0, 1'b1, "reset pc");
    rd_chk(OFS_PWR_FLAGS, 32'h0, 32'h2, 1'b0);
    rd_chk(OFS_INT_STAT, 32'h1, 32'h1, 1'b0);
    chk_bit(irq, 1'b1, "irq not raised");
    wr(OFS_INT_CLR, 32'h1f);
    rd_chk(OFS_INT_STAT, 32'h0, 32'h1f, 1'b0);
    chk_bit(irq, 1'b0, "irq stuck");
    wr(OFS_PWR_FLAGS, 32'h3);
    master_clear_n_hold <= 1'b1;
    repeat (8) @(posedge pclk);
    chk_bit(core_reset, 1'b1, "master_clear_n ignored");
    rd_chk(OFS_SEQ_STATE, 32'hc, 32'hf, 1'b0);
    master_clear_n_hold <= 1'b0;
    wait_run(n);
    rd_chk(OFS_PWR_FLAGS, 32'h3, 32'h3, 1'b0);
    rd_chk(OFS_CORE_STAT, 32'h18, 32'h18, 1'b0);
    // delay disabled on purpose: brown-out must still force it
    wr(OFS_CONFIG, 32'h3);
    vdd_low <= 1'b1;
    repeat (BQ - 2) @(posedge pclk);
    vdd_low <= 1'b0;
    repeat (10) @(posedge pclk);
    chk_bit(core_reset, 1'b0, "short dip reset");
    vdd_low <= 1'b1;
    repeat (30) @(posedge pclk);
    chk_bit(core_reset, 1'b1, "brown-out missed");
    vdd_low <= 1'b0;
    repeat (10) @(posedge pclk);
    vdd_low <= 1'b1;
    repeat (30) @(posedge pclk);
    vdd_low <= 1'b0;
    wait_run(n);
    chk_bit(n >= PW, 1'b1, "brown-out hold short");
    rd_chk(OFS_PWR_FLAGS, 32'h2, 32'h3, 1'b0);
    wr(OFS_CONFIG, 32'hd);
    n = loads;
    fire(3'h1);
    chk_bit(loads == n + 1 && last_pc === 13'h0, 1'b1, "wdt reset pc");
    rd_chk(OFS_CORE_STAT, 32'h08, 32'h18, 1'b0);
    for (int i = 0; i < 3; i++) begin
      global_int_enable <= (i == 0);
      fire(3'h4);
      rd_chk(OFS_CORE_STAT, 32'h10, 32'h18, 1'b0);
      fire(i == 2 ? 3'h1 : 3'h2);
      chk_word({19'h0, last_pc}, i == 0 ? 32'h4 : 32'h124, "wake pc");
      chk_bit(core_reset, 1'b0, "rc wake held");
      rd_chk(OFS_CORE_STAT, i == 2 ? 32'h0 : 32'h10, 32'h18, 1'b0);
    end
    wr(OFS_CONFIG, 32'h5);
    fire(3'h4);
    fire(3'h2);
    wait_run(n);
    chk_bit(n + 13 >= (OC - 1) * 8, 1'b1, "wake start-up short");
    wr(OFS_INT_EN, 32'h0);
    rd_chk(OFS_INT_STAT, 32'h8, 32'h8, 1'b0);
    chk_bit(irq, 1'b0, "masked irq");
    // repower with the pin held: start-up count finishes behind it
    master_clear_n_hold <= 1'b1;
    vdd_on <= 1'b0;
    repeat (10) @(posedge pclk);
    vdd_on <= 1'b1;
    repeat (200) @(posedge pclk);
    chk_bit(core_reset, 1'b1, "master_clear_n low released");
    master_clear_n_hold <= 1'b0;
    wait_run(n);
    chk_bit(n <= 6, 1'b1, "release after master_clear_n slow");
    rd_chk(OFS_PWR_FLAGS, 32'h0, 32'h2, 1'b0);
    // rc mode with delay on: power-up delay only, no start-up count
    wr(OFS_CONFIG, 32'hc);
    vdd_on <= 1'b0;
    repeat (10) @(posedge pclk);
    vdd_on <= 1'b1;
    wait_run(n);
    chk_bit(n >= PW && n < PW + 16, 1'b1, "rc power-up hold");
    stop_test();
  end
endmodule
